// ---- hdl/plm_led_decode.sv ----
// Function decoder for one LED from its selector code and table choice.
`timescale 1ns/100ps
`default_nettype none
module plm_led_decode (
  // Selection
  input  wire logic [plm_pkg::SEL_W-1:0] sel,
  input  wire logic                      extended,
  // Status
  plm_stat_if.sink                       st,
  // Result
  output var  logic                      lit
);
  logic act;
  logic sp10;
  logic sp100;
  logic sp1000;

  always_comb begin
    act    = st.tx | st.rx;
    sp10   = st.link_up & (st.speed == plm_pkg::SPEED_10);
    sp100  = st.link_up & (st.speed == plm_pkg::SPEED_100);
    sp1000 = st.link_up & (st.speed == plm_pkg::SPEED_1000);
    lit    = 1'b0; // R13
    if (extended) begin // R12
      unique case (sel)
        4'h0:    lit = sp10 | sp100; // R10
        4'h2:    lit = sp100 & ~(act & st.blink); // R11
        default: lit = 1'b0; // R13
      endcase
    end else begin
      unique case (sel)
        4'h0:    lit = sp1000; // R7
        4'h1:    lit = sp100; // R7
        4'h2:    lit = sp10 | (sp100 & st.blink); // R7
        4'h4:    lit = st.link_up; // R8
        4'h5:    lit = st.tx; // R8
        4'h6:    lit = st.rx; // R8
        4'h7:    lit = act; // R8
        4'h8:    lit = st.link_up & st.full_duplex; // R8
        4'h9:    lit = st.col; // R8
        4'hA:    lit = st.link_up & ~(act & st.blink); // R9
        4'hB:    lit = st.link_up & ~(st.rx & st.blink); // R9
        4'hD:    lit = st.blink; // R9
        4'hE:    lit = 1'b1; // R9
        4'hF:    lit = 1'b0; // R9
        default: lit = 1'b0; // R13
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hdl/plm_stretch.sv ----
// Pulse stretcher for one LED event, counted in step ticks.
`timescale 1ns/100ps
`default_nettype none
module plm_stretch (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Control
  input  wire logic                        enable,
  input  wire logic                        tick,
  input  wire logic [plm_pkg::UNIT_W-1:0]  length,
  // Event
  input  wire logic                        event_in,
  output var  logic                        event_out
);
  logic [plm_pkg::UNIT_W-1:0] remain;

  // A new event reloads the count, so back-to-back events extend the pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= '0;
    end else if (event_in) begin
      remain <= length;
    end else if (tick && remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  always_comb begin
    event_out = event_in | (enable & (remain != '0)); // R5
  end
endmodule
`default_nettype wire

// ---- hdl/plm_top.sv ----
// Top of the LED mode control block with its APB register file.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: Duration code 00 stretches events to 32 ms, 01 to 64 ms, 10 to 104 ms.
// R2: Duration code 11 takes the stretch length from the extended setting, 0 to 2 s in 4 ms steps.
// R3: The output disable bit set forces every LED inactive, cleared lets each follow its function.
// R4: The output disable bit is loaded after reset from the sampled LED configuration strap.
// R5: With stretch enabled (reset value one) transmit, receive and collision are stretched, else not.
// R6: Four 4-bit selectors at 15:12, 11:8, 7:4 and 3:0 share one code table and reset from the strap.
// R7: Standard codes 0000 gigabit link, 0001 100 Mb link, 0010 on at 10 Mb and blinking at 100 Mb.
// R8: Standard codes 0100 link, 0101 transmit, 0110 receive, 0111 activity, 1000 full duplex, 1001 collision.
// R9: Standard 1010 link with activity blink, 1011 link with receive blink, 1101 blink, 1110 on, 1111 off.
// R10: Extended code 0000 lights for a link at 10 Mb or 100 Mb.
// R11: Extended code 0010 lights for a 100 Mb link and blinks on activity.
// R12: Each LED has its own extended bit choosing the extended or the standard table.
// R13: Codes with no meaning in the active table keep the LED off.
module plm_top #(
  parameter int TICK_CYCLES = plm_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // PHY core status
  input  wire logic        link_up,
  input  wire logic [1:0]  link_speed,
  input  wire logic        full_duplex,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        collision,
  // Strap pin
  input  wire logic        led_config_strap,
  // LED outputs, high lights the LED
  output var  logic        led_ten_meg,
  output var  logic        led_hundred_meg,
  output var  logic        led_gigabit,
  output var  logic        led_link_activity
);
  // ==========================================================================
  // Registers and internal state
  // ==========================================================================
  logic [15:0]                led_control_one;
  logic [15:0]                led_function_select;
  logic [plm_pkg::UNIT_W-1:0] stretch_extended;

  logic                       strap_meta;
  logic                       strap_sync;
  logic [1:0]                 strap_wait;
  logic                       strap_done;
  logic                       strap_load;

  logic [plm_pkg::TICK_W-1:0] tick_count;
  logic                       tick;
  logic [plm_pkg::UNIT_W-1:0] blink_count;
  logic                       blink_phase;

  logic [plm_pkg::UNIT_W-1:0] stretch_len;
  logic                       stretch_en;
  logic                       tx_stretched;
  logic                       rx_stretched;
  logic                       col_stretched;
  logic [3:0]                 lit;
  logic [3:0]                 ext_bits;

  logic                       setup;
  logic                       wr_access;
  logic [9:0]                 addr;
  logic                       mapped;
  logic                       in_page;
  logic [31:0]                next_prdata;
  logic [plm_pkg::UNIT_W-1:0] next_ext;

  plm_stat_if stat ();

  // ==========================================================================
  // Strap sampling
  // ==========================================================================
  // Two flip-flops bring the strap pin into the clock domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_meta <= led_config_strap;
      strap_sync <= strap_meta;
    end
  end

  // Waits two edges so the synchroniser holds the real strap level first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait <= '0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 1'b1;
      strap_done <= (strap_wait == 2'b10);
    end
  end

  // The register file takes the strap level at this single edge.
  assign strap_load = !strap_done && (strap_wait == 2'b10);

  // ==========================================================================
  // APB slave
  // ==========================================================================
  always_comb begin
    setup     = psel & ~penable;
    wr_access = psel & penable & pready & pwrite;
    addr      = paddr[9:0];
    in_page   = (paddr[31:10] == '0);
    // Any other address answers with an error and changes nothing.
    mapped    = in_page &&
                (addr == plm_pkg::ADDR_LED_CONTROL_ONE ||
                 addr == plm_pkg::ADDR_LED_FUNCTION_SELECT ||
                 addr == plm_pkg::ADDR_STRETCH_EXTENDED ||
                 addr == plm_pkg::ADDR_LED_STATUS);
    next_prdata = '0;
    if (in_page) begin
      unique case (addr)
        plm_pkg::ADDR_LED_CONTROL_ONE:     next_prdata = {16'h0000, led_control_one};
        plm_pkg::ADDR_LED_FUNCTION_SELECT: next_prdata = {16'h0000, led_function_select};
        plm_pkg::ADDR_STRETCH_EXTENDED:    next_prdata = {23'h0, stretch_extended};
        plm_pkg::ADDR_LED_STATUS:          next_prdata = {24'h000000, blink_phase, col_stretched,
                                                          rx_stretched, tx_stretched,
                                                          led_ten_meg, led_hundred_meg,
                                                          led_gigabit, led_link_activity};
        default:                           next_prdata = '0;
      endcase
    end
    // Writes beyond two seconds saturate rather than wrap.
    next_ext = (pwdata > 32'(plm_pkg::UNITS_MAX)) ?
               plm_pkg::UNITS_MAX : pwdata[plm_pkg::UNIT_W-1:0];
  end

  // The answer is prepared in the setup cycle so the access phase never waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup && !pwrite) ? next_prdata : '0;
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  // The strap load wins over a write at the same edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_control_one <= plm_pkg::CTRL_RESET;
    end else if (strap_load) begin
      led_control_one[plm_pkg::DISABLE_BIT] <= strap_sync; // R4
      led_control_one[plm_pkg::EXT_TEN_BIT] <= strap_sync;
    end else if (wr_access && addr == plm_pkg::ADDR_LED_CONTROL_ONE && in_page) begin
      led_control_one <= pwdata[15:0] & plm_pkg::CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_function_select <= plm_pkg::SEL_STRAP_LOW;
    end else if (strap_load) begin
      led_function_select <= strap_sync ? plm_pkg::SEL_STRAP_HIGH : plm_pkg::SEL_STRAP_LOW; // R6
    end else if (wr_access && addr == plm_pkg::ADDR_LED_FUNCTION_SELECT && in_page) begin
      led_function_select <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_extended <= plm_pkg::UNITS_MAX;
    end else if (wr_access && addr == plm_pkg::ADDR_STRETCH_EXTENDED && in_page) begin
      stretch_extended <= next_ext; // R2
    end
  end

  // ==========================================================================
  // Step tick and blink phase
  // ==========================================================================
  // The tick divides the clock down to the 4 ms step of every length.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count == plm_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick       <= 1'b0;
    end
  end

  // All blinking codes share this one phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_count <= '0;
      blink_phase <= 1'b0;
    end else if (tick) begin
      if (blink_count == plm_pkg::UNITS_BLINK - 1'b1) begin
        blink_count <= '0;
        blink_phase <= ~blink_phase;
      end else begin
        blink_count <= blink_count + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Stretching
  // ==========================================================================
  // Code 11 hands the length over to the extended setting.
  always_comb begin
    stretch_en = led_control_one[plm_pkg::STRETCH_EN_BIT]; // R5
    unique case (led_control_one[plm_pkg::DUR_HI_BIT:plm_pkg::DUR_LO_BIT])
      plm_pkg::DUR_32:  stretch_len = plm_pkg::UNITS_32; // R1
      plm_pkg::DUR_64:  stretch_len = plm_pkg::UNITS_64; // R1
      plm_pkg::DUR_104: stretch_len = plm_pkg::UNITS_104; // R1
      plm_pkg::DUR_EXT: stretch_len = stretch_extended; // R2
    endcase
  end

  // Each event has its own stretcher on the shared tick.
  plm_stretch u_tx_stretch (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (stretch_en),
    .tick      (tick),
    .length    (stretch_len),
    .event_in  (tx_active),
    .event_out (tx_stretched)
  );

  plm_stretch u_rx_stretch (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (stretch_en),
    .tick      (tick),
    .length    (stretch_len),
    .event_in  (rx_active),
    .event_out (rx_stretched)
  );

  plm_stretch u_col_stretch (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (stretch_en),
    .tick      (tick),
    .length    (stretch_len),
    .event_in  (collision),
    .event_out (col_stretched)
  );

  // ==========================================================================
  // Decoding and outputs
  // ==========================================================================
  assign stat.link_up     = link_up;
  assign stat.speed       = link_speed;
  assign stat.full_duplex = full_duplex;
  assign stat.tx          = tx_stretched;
  assign stat.rx          = rx_stretched;
  assign stat.col         = col_stretched;
  assign stat.blink       = blink_phase;
  assign ext_bits         = led_control_one[plm_pkg::EXT_TEN_BIT:plm_pkg::EXT_LOW_BIT];

  // Index 3 is the ten-megabit LED, index 0 the link/activity LED.
  for (genvar i = 0; i < plm_pkg::NUM_LEDS; i++) begin : g_led
    plm_led_decode u_decode (
      .sel      (led_function_select[i*plm_pkg::SEL_W +: plm_pkg::SEL_W]), // R6
      .extended (ext_bits[i]), // R12
      .st       (stat),
      .lit      (lit[i])
    );
  end

  // The disable bit masks the LEDs at the output flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ten_meg       <= 1'b0;
      led_hundred_meg   <= 1'b0;
      led_gigabit       <= 1'b0;
      led_link_activity <= 1'b0;
    end else begin
      led_ten_meg       <= lit[3] & ~led_control_one[plm_pkg::DISABLE_BIT]; // R3
      led_hundred_meg   <= lit[2] & ~led_control_one[plm_pkg::DISABLE_BIT]; // R3
      led_gigabit       <= lit[1] & ~led_control_one[plm_pkg::DISABLE_BIT]; // R3
      led_link_activity <= lit[0] & ~led_control_one[plm_pkg::DISABLE_BIT]; // R3
    end
  end
endmodule
`default_nettype wire

// ---- include/plm_pkg.sv ----
// Package with register map, field layout and timing constants of the LED mode control block.
package plm_pkg;
  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [7:0]  IDX_LED_CONTROL_ONE     = 8'h1B;
  localparam logic [7:0]  IDX_LED_FUNCTION_SELECT = 8'h1C;
  localparam logic [7:0]  IDX_STRETCH_EXTENDED    = 8'h20;
  localparam logic [7:0]  IDX_LED_STATUS          = 8'h21;
  localparam logic [9:0]  ADDR_LED_CONTROL_ONE     = {IDX_LED_CONTROL_ONE, 2'b00};
  localparam logic [9:0]  ADDR_LED_FUNCTION_SELECT = {IDX_LED_FUNCTION_SELECT, 2'b00};
  localparam logic [9:0]  ADDR_STRETCH_EXTENDED    = {IDX_STRETCH_EXTENDED, 2'b00};
  localparam logic [9:0]  ADDR_LED_STATUS          = {IDX_LED_STATUS, 2'b00};

  // ==========================================================================
  // Field layout of led_control_one
  // ==========================================================================
  localparam int          EXT_TEN_BIT     = 13;
  localparam int          EXT_LOW_BIT     = 10;
  localparam int          DUR_HI_BIT      = 3;
  localparam int          DUR_LO_BIT      = 2;
  localparam int          DISABLE_BIT     = 1;
  localparam int          STRETCH_EN_BIT  = 0;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h3C0F;
  localparam logic [15:0] CTRL_RESET      = 16'h0001;

  // Selector defaults loaded from the strap, chosen per strap level.
  localparam logic [15:0] SEL_STRAP_LOW   = 16'h104A;
  localparam logic [15:0] SEL_STRAP_HIGH  = 16'h0107;

  // ==========================================================================
  // Speed encoding of the PHY core status
  // ==========================================================================
  localparam logic [1:0]  SPEED_10   = 2'b00;
  localparam logic [1:0]  SPEED_100  = 2'b01;
  localparam logic [1:0]  SPEED_1000 = 2'b10;

  // ==========================================================================
  // Stretch duration codes
  // ==========================================================================
  localparam logic [1:0]  DUR_32   = 2'b00;
  localparam logic [1:0]  DUR_64   = 2'b01;
  localparam logic [1:0]  DUR_104  = 2'b10;
  localparam logic [1:0]  DUR_EXT  = 2'b11;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          PCLK_KHZ      = 40000;
  localparam int          STEP_MS       = 4;
  localparam int          STEP_CYCLES   = STEP_MS * PCLK_KHZ;
  localparam int          STRETCH_32_MS  = 32;
  localparam int          STRETCH_64_MS  = 64;
  localparam int          STRETCH_104_MS = 104;
  localparam int          STRETCH_MAX_MS = 2000;
  localparam int          BLINK_HALF_MS  = 256;
  localparam int          UNIT_W         = 9;
  localparam logic [UNIT_W-1:0] UNITS_32  = UNIT_W'(STRETCH_32_MS / STEP_MS);
  localparam logic [UNIT_W-1:0] UNITS_64  = UNIT_W'(STRETCH_64_MS / STEP_MS);
  localparam logic [UNIT_W-1:0] UNITS_104 = UNIT_W'(STRETCH_104_MS / STEP_MS);
  localparam logic [UNIT_W-1:0] UNITS_MAX = UNIT_W'(STRETCH_MAX_MS / STEP_MS);
  localparam logic [UNIT_W-1:0] UNITS_BLINK = UNIT_W'(BLINK_HALF_MS / STEP_MS);
  localparam int          TICK_W        = 18;
  localparam int          NUM_LEDS      = 4;
  localparam int          SEL_W         = 4;
endpackage

// ---- include/plm_stat_if.sv ----
// Interface carrying conditioned link status from the top to the LED decoders.
`timescale 1ns/100ps
`default_nettype none
interface plm_stat_if;
  logic       link_up;
  logic [1:0] speed;
  logic       full_duplex;
  logic       tx;
  logic       rx;
  logic       col;
  logic       blink;
  modport drive (output link_up, speed, full_duplex, tx, rx, col, blink);
  modport sink  (input  link_up, speed, full_duplex, tx, rx, col, blink);
endinterface
`default_nettype wire

// ---- tb/plm_top_checker.sv ----
// Port checker of the LED mode control block, bound to its top.
`timescale 1ns/100ps
`default_nettype none
module plm_top_checker #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status and LEDs
  input wire logic        tx_active,
  input wire logic        led_ten_meg,
  input wire logic        led_hundred_meg,
  input wire logic        led_gigabit,
  input wire logic        led_link_activity
);
  localparam logic [31:0] A_CTRL = 32'(plm_pkg::ADDR_LED_CONTROL_ONE);
  localparam logic [31:0] A_SEL  = 32'(plm_pkg::ADDR_LED_FUNCTION_SELECT);
  logic        acc, setup, mapped, std_lnk;
  logic [1:0]  known;
  logic [15:0] ctrl_sh, sel_sh;
  logic [3:0]  leds;
  // ====================
  // Register shadows
  // ====================
  assign acc     = psel && penable && pready;
  assign setup   = psel && !penable;
  assign mapped  = paddr inside {A_CTRL, A_SEL, 32'(plm_pkg::ADDR_STRETCH_EXTENDED), 32'(plm_pkg::ADDR_LED_STATUS)};
  assign std_lnk = &known && !ctrl_sh[1] && !ctrl_sh[10];
  assign leds    = {led_ten_meg, led_hundred_meg, led_gigabit, led_link_activity};
  // The shadows only count once software has written them, so strap defaults never matter here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      known   <= 2'h0;
      ctrl_sh <= 16'h0000;
      sel_sh  <= 16'h0000;
    end else if (acc && pwrite && paddr == A_CTRL) begin
      ctrl_sh  <= pwdata[15:0] & plm_pkg::CTRL_WRITE_MASK;
      known[0] <= 1'b1;
    end else if (acc && pwrite && paddr == A_SEL) begin
      sel_sh   <= pwdata[15:0];
      known[1] <= 1'b1;
    end
  end
  // ====================
  // Assertions
  // ====================
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY:
    assert property (pready == $past(setup)) else $error("pready not one cycle after setup");
  AST_SLVERR:
    assert property (pslverr == ($past(setup) && !$past(mapped))) else $error("pslverr wrong");
  AST_RDATA_IDLE:
    assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  AST_DISABLE:
    assert property (acc && pwrite && paddr == A_CTRL && pwdata[1] |=> ##1 (leds == 4'h0) [*2])
      else $error("LED lit while disabled");
  AST_CTRL_RB:
    assert property (acc && !pwrite && paddr == A_CTRL && known[0] |-> prdata == {16'h0, ctrl_sh})
      else $error("control readback wrong");
  AST_SEL_RB:
    assert property (acc && !pwrite && paddr == A_SEL && known[1] |-> prdata == {16'h0, sel_sh})
      else $error("selector readback wrong");
  AST_FORCE:
    assert property (std_lnk && sel_sh[3:1] == 3'h7 && $stable(sel_sh) && $stable(ctrl_sh)
      |=> led_link_activity != $past(sel_sh[0])) else $error("forced LED wrong");
  AST_NO_STRETCH:
    assert property (std_lnk && !ctrl_sh[0] && sel_sh[3:0] == 4'h5 && $stable(sel_sh) && $stable(ctrl_sh)
      |=> led_link_activity == $past(tx_active)) else $error("transmit LED wrong");
  COV_UNMAPPED: cover property (acc && pslverr);
  COV_TX_PLAIN: cover property (std_lnk && !ctrl_sh[0] && sel_sh[3:0] == 4'h5 && tx_active);
  COV_FORCE_ON: cover property (std_lnk && sel_sh[3:0] == 4'hE && led_link_activity);
endmodule
bind plm_top plm_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_active(tx_active), .led_ten_meg(led_ten_meg), .led_hundred_meg(led_hundred_meg),
  .led_gigabit(led_gigabit), .led_link_activity(led_link_activity)
);
`default_nettype wire

// ---- tb/plm_top_tb.sv ----
// Self-checking testbench of the LED mode control block.
`timescale 1ns/100ps
`default_nettype none
module plm_top_tb;
  localparam int          TK     = 4;
  localparam logic [31:0] A_CTRL = 32'(plm_pkg::ADDR_LED_CONTROL_ONE);
  localparam logic [31:0] A_SEL  = 32'(plm_pkg::ADDR_LED_FUNCTION_SELECT);
  localparam logic [31:0] A_EXT  = 32'(plm_pkg::ADDR_STRETCH_EXTENDED);
  // Entry nibbles: extended bit, code, {link, speed, duplex}, {tx, rx, collision, expected LED}.
  localparam logic [15:0] TBL [30] = '{
    16'h00C1, 16'h00A0, 16'h01A1, 16'h01C0, 16'h0281, 16'h03DE, 16'h0CDE, 16'h0481, 16'h0400, 16'h0509,
    16'h0605, 16'h0608, 16'h0705, 16'h0700, 16'h0891, 16'h0880, 16'h0903, 16'h0908, 16'h0A81, 16'h0A00,
    16'h0B81, 16'h0E01, 16'h0FDE, 16'h1081, 16'h10A1, 16'h10C0, 16'h1000, 16'h12A1, 16'h1280, 16'h1480
  };
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, led_config_strap, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [6:0]  st;
  logic [3:0]  leds;
  int          bad_count;
  int          checks;

  plm_top #(.TICK_CYCLES(TK)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(st[6]), .link_speed(st[5:4]), .full_duplex(st[3]), .tx_active(st[2]),
    .rx_active(st[1]), .collision(st[0]), .led_config_strap(led_config_strap),
    .led_ten_meg(leds[3]), .led_hundred_meg(leds[2]), .led_gigabit(leds[1]), .led_link_activity(leds[0])
  );
  // ====================
  // Tasks
  // ====================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready", {31'h0, pready}, 32'h1);
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic do_reset(input logic strap);
    presetn          <= 1'b0;
    led_config_strap <= strap;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // One event cycle, then the LED high time is counted against the programmed units.
  task automatic stretch(input logic [3:0] code, input logic [2:0] ev, input int units, input logic [31:0] ctrl);
    int n = 0;
    apb(1'b1, A_SEL, {16'h0, {4{code}}});
    apb(1'b1, A_CTRL, ctrl);
    st[2:0] <= ev;
    @(posedge pclk);
    st[2:0] <= 3'h0;
    repeat (200) begin
      @(posedge pclk);
      if (leds[0] === 1'b1) n++;
    end
    check("stretch_cycles", 32'(n >= units * TK - 4 && n <= units * TK + 5), 32'h1);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ====================
  // Tests
  // ====================
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    check("watchdog", 32'h0, 32'h1);
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, led_config_strap, st} = '0;
    bad_count = 0;
    checks = 0;
    @(posedge pclk);
    do_reset(1'b0);
    rdc(A_CTRL, 32'h0000_0001, "ctrl_reset");
    rdc(A_SEL, 32'h0000_104A, "sel_reset");
    rdc(A_EXT, 32'h0000_01F4, "ext_reset");
    apb(1'b0, 32'h0000_0010, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, 32'(plm_pkg::ADDR_LED_STATUS), 32'h0000_00FF);
    check("status_write_err", {31'h0, err}, 32'h0);
    apb(1'b1, A_CTRL, 32'h0000_FFFF);
    rdc(A_CTRL, 32'h0000_3C0F, "ctrl_mask");
    apb(1'b1, A_EXT, 32'h0000_0258);
    rdc(A_EXT, 32'h0000_01F4, "ext_clamp");
    foreach (TBL[i]) begin
      st <= {TBL[i][7:4], TBL[i][3:1]};
      apb(1'b1, A_CTRL, {18'h0, {4{TBL[i][12]}}, 10'h0});
      apb(1'b1, A_SEL, {16'h0, {4{TBL[i][11:8]}}});
      @(posedge pclk);
      check("led_code", {28'h0, leds}, {28'h0, {4{TBL[i][0]}}});
    end
    st <= 7'h40;
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_SEL, 32'h0000_EFEE);
    @(posedge pclk);
    check("led_positions", {28'h0, leds}, 32'hB);
    apb(1'b1, A_SEL, 32'h0000_4444);
    apb(1'b1, A_CTRL, 32'h0000_0800);
    @(posedge pclk);
    check("led_one_extended", {28'h0, leds}, 32'hD);
    apb(1'b1, A_CTRL, 32'h0000_0002);
    @(posedge pclk);
    check("led_disabled", {28'h0, leds}, 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    @(posedge pclk);
    check("led_enabled", {28'h0, leds}, 32'hF);
    stretch(4'h5, 3'h4, 8, 32'h1);
    stretch(4'h5, 3'h4, 16, 32'h5);
    stretch(4'h5, 3'h4, 26, 32'h9);
    apb(1'b1, A_EXT, 32'h3);
    stretch(4'h5, 3'h4, 3, 32'hD);
    apb(1'b1, A_EXT, 32'h0);
    stretch(4'h5, 3'h4, 0, 32'hD);
    stretch(4'h6, 3'h2, 8, 32'h1);
    stretch(4'h9, 3'h1, 8, 32'h1);
    stretch(4'h5, 3'h4, 0, 32'h0);
    st <= 7'h60;
    do_reset(1'b1);
    rdc(A_CTRL, 32'h0000_2003, "ctrl_strap");
    rdc(A_SEL, 32'h0000_0107, "sel_strap");
    check("led_strap_off", {28'h0, leds}, 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    @(posedge pclk);
    check("led_strap_sel", {28'h0, leds}, 32'hA);
    end_sim();
  end
endmodule
`default_nettype wire
